// *** maskable_irq_request_logic.sv ***
// Maskable interrupt request logic: pin sense, peripheral flags, shared request.
// Assumes all inputs synchronous to clk_sys and e_tick pulsing once per E clock.
// How it works
// - Edge mode latches a request on a falling edge of the pin.
// - Edge latch holds no source identity; only one requester distinguishable.
// - Level mode: shared line may stay low; each source keeps a flag.
// - Handshake I/O and pin requests share one common vector request.
// - Expanded modes hand the 18 handshake pins to the expansion bus.
// - Expanded modes decode handshake register addresses as external accesses.
// - Edge mode misses new edges while the line is already held low.
// - Timer, peripheral and receive sources request only when flag and enable are both set; hs_irq requests with no enable.
// - The global mask bit blocks all maskable requests from the CPU.
// - Writing one clears a timer flag; writing zero leaves it.
// - Receive-full clears after status read while set, then data read.
// - I/O and serial flags clear by normal service accesses only.
// - Memory-zero read of data register counts as the second step.
// - Edge select zero means low level, one means falling edge.
// - Edge select writable once within first 64 E clocks; resets zero.
// - An enabled flag holds its request until software clears it.
module maskable_irq_request_logic
  import irq_pkg::*;
#(
  parameter int unsigned NT = N_TIMER_FLAGS,
  parameter int unsigned NP = N_PERIPH
) (
  input  logic                   clk_sys,
  input  logic                   arst_n,
  input  logic                   e_tick,
  input  logic                   irq_pin_n,
  input  logic                   expanded_mode,
  input  logic                   edge_sel_wr,
  input  logic                   edge_sel_wdata,
  input  logic                   mask_bit,
  input  logic                   irq_ack,
  input  logic                   hs_irq,
  input  logic                   hs_addr_hit,
  input  logic [NT-1:0]          timer_set,
  input  logic [NT-1:0]          timer_en,
  input  logic                   timer_wr,
  input  logic [NT-1:0]          timer_wdata,
  input  logic [NP-1:0]          periph_flag,
  input  logic [NP-1:0]          periph_en,
  input  logic                   rx_set,
  input  logic                   rx_en,
  input  irq_pkg::serial_access_t ser_acc,
  output logic                   pin_edge_select,
  output logic [NT-1:0]          timer_flags,
  output logic                   rx_full_flag,
  output logic                   shared_req,
  output logic                   cpu_irq,
  output logic                   hs_pins_to_bus,
  output logic                   hs_addr_external
);
  import irq_pkg::*;

  logic [6:0]    prot_cnt_q;
  logic          edge_written_q;
  logic          pin_q;
  logic          edge_latch_q;
  logic          rx_armed_q;
  logic [NT-1:0] tflag_q;
  logic          rx_q;
  logic          shared_d;

  // Falling-edge decode, shared by the latch and by its checks.
  function automatic logic falling_seen(input logic was_high, input logic now_n);
    return was_high && !now_n;
  endfunction

  // Edge select: time protected and write-once, so a runaway program cannot flip it.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      prot_cnt_q      <= 7'h00;
      edge_written_q  <= 1'b0;
      pin_edge_select <= 1'(PIN_EDGE_SELECT_RST);
    end else begin
      if (e_tick && prot_cnt_q != PROT_CNT_W) begin
        prot_cnt_q <= prot_cnt_q + 7'h01;
      end
      if (edge_sel_wr && !edge_written_q && prot_cnt_q != PROT_CNT_W) begin
        pin_edge_select <= edge_sel_wdata;
        edge_written_q  <= 1'b1;
      end
    end
  end

  // Falling-edge latch; a line already low yields no edge from a second source.
  // It only arms in edge mode, so an edge seen under level sense cannot fire later.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pin_q        <= 1'b1;
      edge_latch_q <= 1'b0;
    end else begin
      pin_q <= irq_pin_n;
      if (pin_edge_select && falling_seen(pin_q, irq_pin_n)) begin
        edge_latch_q <= 1'b1;
      end else if (irq_ack) begin
        edge_latch_q <= 1'b0;
      end
    end
  end

  // Timer flags: hardware set wins over a simultaneous write-one clear.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tflag_q <= '0;
    end else begin
      tflag_q <= timer_set | (tflag_q & ~(timer_wr ? timer_wdata : {NT{1'b0}}));
    end
  end

  // Receive-full: status read while set arms; data read (or memory-zero read) clears.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rx_q       <= 1'b0;
      rx_armed_q <= 1'b0;
    end else begin
      if (rx_set) begin
        rx_q       <= 1'b1;
        rx_armed_q <= ser_acc.rd_status ? 1'b1 : rx_armed_q;
      end else if (rx_armed_q && (ser_acc.rd_data || ser_acc.rmw_zero)) begin
        rx_q       <= 1'b0;
        rx_armed_q <= 1'b0;
      end else if (ser_acc.rd_status && rx_q) begin
        rx_armed_q <= 1'b1;
      end
    end
  end

  // Pin in level mode is passed through; each source keeps its own flag upstream.
  always_comb begin
    shared_d = (pin_edge_select ? edge_latch_q : !irq_pin_n)
             | hs_irq
             | (|(tflag_q & timer_en))
             | (|(periph_flag & periph_en))
             | (rx_q & rx_en);
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      shared_req       <= 1'b0;
      cpu_irq          <= 1'b0;
      timer_flags      <= '0;
      rx_full_flag     <= 1'b0;
      hs_pins_to_bus   <= 1'b0;
      hs_addr_external <= 1'b0;
    end else begin
      shared_req       <= shared_d;
      cpu_irq          <= shared_d & !mask_bit;
      timer_flags      <= tflag_q;
      rx_full_flag     <= rx_q;
      hs_pins_to_bus   <= expanded_mode;
      hs_addr_external <= expanded_mode & hs_addr_hit;
    end
  end

  // Checks of the request path; each one watches a register that the logic above drives.
  a_mask_blocks: assert property (@(posedge clk_sys) disable iff (!arst_n)
    mask_bit |=> !cpu_irq) else $error("masked request reached cpu");
  a_edge_latch: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (pin_edge_select && falling_seen(pin_q, irq_pin_n)) |=> edge_latch_q)
    else $error("falling edge missed");
  a_timer_clear: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (timer_wr && timer_wdata[0] && !timer_set[0]) |=> !tflag_q[0])
    else $error("timer flag not cleared");
  a_timer_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (tflag_q[0] && !(timer_wr && timer_wdata[0])) |=> tflag_q[0])
    else $error("timer flag lost");
  a_rx_needs_arm: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (rx_q && !rx_armed_q) |=> rx_q) else $error("rx flag cleared unarmed");
  a_rx_clear: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (rx_armed_q && ser_acc.rmw_zero && !rx_set) |=> !rx_q)
    else $error("rx flag kept after zero access");
  a_edge_sel_lock: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (prot_cnt_q == PROT_CNT_W) |=> $stable(pin_edge_select))
    else $error("edge select changed late");
  a_expand_pins: assert property (@(posedge clk_sys) disable iff (!arst_n)
    expanded_mode |=> hs_pins_to_bus) else $error("pins not handed to bus");
  a_shared_vec: assert property (@(posedge clk_sys) disable iff (!arst_n)
    hs_irq |=> shared_req) else $error("handshake request lost");
  a_ack_clears: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (irq_ack && !(pin_edge_select && falling_seen(pin_q, irq_pin_n))) |=> !edge_latch_q)
    else $error("ack did not clear edge");
  a_level_pass: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (!pin_edge_select && !irq_pin_n) |=> shared_req)
    else $error("low pin not passed in level mode");
  a_edge_no_level: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (pin_edge_select && !edge_latch_q && !hs_irq && !(|(tflag_q & timer_en))
     && !(|(periph_flag & periph_en)) && !(rx_q && rx_en)) |=> !shared_req)
    else $error("level seen in edge mode");
  a_low_no_edge: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (pin_edge_select && !pin_q && !edge_latch_q) |=> !edge_latch_q)
    else $error("edge taken from a held low line");
  a_level_no_latch: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (!pin_edge_select && !edge_latch_q) |=> !edge_latch_q)
    else $error("edge latched in level mode");
  a_periph_req: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (|(periph_flag & periph_en)) |=> shared_req)
    else $error("peripheral request lost");
  a_timer_req: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (|(tflag_q & timer_en)) |=> shared_req)
    else $error("timer request lost");
  a_rx_req: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (rx_q && rx_en) |=> shared_req)
    else $error("receive request lost");
  a_timer_set: assert property (@(posedge clk_sys) disable iff (!arst_n)
    timer_set[0] |=> tflag_q[0])
    else $error("timer flag not set");
  a_unmask_pass: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (shared_d && !mask_bit) |=> cpu_irq)
    else $error("unmasked request blocked");
  a_addr_external: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (expanded_mode && hs_addr_hit) |=> hs_addr_external)
    else $error("handshake address kept internal");
  a_single_chip: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !expanded_mode |=> (!hs_pins_to_bus && !hs_addr_external))
    else $error("expansion active in single chip");
  a_edge_sel_once: assert property (@(posedge clk_sys) disable iff (!arst_n)
    edge_written_q |=> $stable(pin_edge_select))
    else $error("edge select written twice");
  a_rx_arm: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (ser_acc.rd_status && rx_q && !ser_acc.rd_data && !ser_acc.rmw_zero) |=> rx_armed_q)
    else $error("status read did not arm");
  a_rx_data_clear: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (rx_armed_q && ser_acc.rd_data && !rx_set) |=> !rx_q)
    else $error("rx flag kept after data read");
endmodule // maskable_irq_request_logic

// *** irq_pkg.sv ***
// Package for the maskable interrupt request logic: timing counts and port bundles.
// Assumes one system clock; the E-clock rate is given as a one-cycle enable pulse.
package irq_pkg;
  localparam int unsigned PROT_WINDOW_ECLK = 64;
  localparam int unsigned PIN_EDGE_SELECT_RST = 0;
  localparam int unsigned N_TIMER_FLAGS = 8;
  localparam int unsigned N_PERIPH = 4;
  localparam int unsigned N_HS_PINS = 18;
  localparam logic [6:0] PROT_CNT_W = 7'h40;

  typedef struct packed {
    logic rd_status;
    logic rd_data;
    logic rmw_zero;
  } serial_access_t;
endpackage : irq_pkg

// *** ext_sources.sv ***
// Far-side model: the user's interrupt source and the port replacement unit on one line.
// Assumes an open-drain line with a pull-up, so the pin rests high when nobody pulls.
module ext_sources (
  input  wire logic replacement_req,
  input  wire logic ext_req,
  output logic      irq_pin_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // Either source pulls low; the wired line carries no record of which one did.
  assign irq_pin_n = ~(replacement_req | ext_req);
endmodule // ext_sources

// *** maskable_irq_request_logic_tb_top.sv ***
// Bench for the maskable interrupt request logic: a queue of expected outputs and a monitor.
// Assumes every output settles within four clocks of the input change that causes it.
module maskable_irq_request_logic_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import irq_pkg::*;
  `define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
    $display("Error %0t: outputs %h expected %h", $time, g, e); end end
  logic clk_sys = 1'b0, arst_n = 1'b0, e_tick = 1'b0, edge_sel_wr = 1'b0, edge_sel_wdata = 1'b0;
  logic mask_bit = 1'b0, irq_ack = 1'b0, hs_irq = 1'b0, hs_addr_hit = 1'b0, expanded_mode = 1'b0;
  logic timer_wr = 1'b0, rx_set = 1'b0, rx_en = 1'b0, replacement_req = 1'b0, ext_req = 1'b0;
  logic chk = 1'b0;
  logic [3:0] periph_flag = 4'h0, periph_en = 4'h0;
  logic [13:0] exp_q;
  logic [7:0] timer_set = 8'h00, timer_en = 8'h00, timer_wdata = 8'h00, tf, b;
  logic irq_pin_n, rxf, shr, cpu, pes, hsb, hsx;
  serial_access_t ser_acc = '0;
  logic [13:0] q[$];
  int n_fail = 0, comparisons = 0;
  always #2 clk_sys = ~clk_sys;
  // The E clock runs at a random fraction of the system clock.
  always @(negedge clk_sys) e_tick <= ($urandom_range(7) == 0);
  ext_sources ext_sources_i (.replacement_req(replacement_req), .ext_req(ext_req),
    .irq_pin_n(irq_pin_n));
  maskable_irq_request_logic maskable_irq_request_logic_i (.clk_sys(clk_sys), .arst_n(arst_n),
    .e_tick(e_tick), .irq_pin_n(irq_pin_n), .expanded_mode(expanded_mode),
    .edge_sel_wr(edge_sel_wr), .edge_sel_wdata(edge_sel_wdata), .mask_bit(mask_bit),
    .irq_ack(irq_ack), .hs_irq(hs_irq), .hs_addr_hit(hs_addr_hit), .timer_set(timer_set),
    .timer_en(timer_en), .timer_wr(timer_wr), .timer_wdata(timer_wdata),
    .periph_flag(periph_flag), .periph_en(periph_en), .rx_set(rx_set), .rx_en(rx_en),
    .ser_acc(ser_acc),
    .pin_edge_select(pes), .timer_flags(tf), .rx_full_flag(rxf), .shared_req(shr),
    .cpu_irq(cpu), .hs_pins_to_bus(hsb), .hs_addr_external(hsx));
  task automatic step(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask
  // Waits for the outputs to settle, then files the note that the monitor checks.
  task automatic expect_out(input logic [13:0] e);
    step(4);
    q.push_back(e);
    chk = 1'b1;
    step(1);
    chk = 1'b0;
  endtask
  task automatic ser(input logic [2:0] a);
    ser_acc = a;
    step(1);
    ser_acc = '0;
  endtask
  task automatic final_report;
    if (n_fail == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // The note is taken off once, so a mismatch cannot pull a second one from the queue.
  always @(posedge clk_sys) if (chk) begin
    exp_q = q.pop_front();
    `CHK({tf, rxf, shr, cpu, pes, hsb, hsx}, exp_q)
  end
  initial begin
    void'($urandom(32'hED77B0EA));
    step(20);
    arst_n = 1'b1;
    expect_out(14'h0000);
    ext_req = 1'b1;
    expect_out({8'h00, 6'h18});
    mask_bit = 1'b1;
    expect_out({8'h00, 6'h10});
    replacement_req = 1'b1;
    ext_req = 1'b0;
    expect_out({8'h00, 6'h10});
    replacement_req = 1'b0;
    mask_bit = 1'b0;
    hs_irq = 1'b1;
    expect_out({8'h00, 6'h18});
    hs_irq = 1'b0;
    expanded_mode = 1'b1;
    hs_addr_hit = 1'b1;
    expect_out({8'h00, 6'h03});
    expanded_mode = 1'b0;
    expect_out({8'h00, 6'h00});
    hs_addr_hit = 1'b0;
    periph_flag = 4'h1 << $urandom_range(3);
    expect_out({8'h00, 6'h00});
    periph_en = periph_flag;
    expect_out({8'h00, 6'h18});
    periph_flag = 4'h0;
    b = 8'h01 << $urandom_range(7);
    timer_set = b;
    step(1);
    timer_set = 8'h00;
    expect_out({b, 6'h00});
    timer_en = b;
    expect_out({b, 6'h18});
    timer_wdata = ~b;
    pulse(timer_wr);
    expect_out({b, 6'h18});
    timer_wdata = b;
    pulse(timer_wr);
    expect_out({8'h00, 6'h00});
    rx_en = 1'b1;
    pulse(rx_set);
    ser(3'h2);
    expect_out({8'h00, 6'h38});
    ser(3'h4);
    ser(3'h2);
    expect_out({8'h00, 6'h00});
    pulse(rx_set);
    ser(3'h4);
    ser(3'h1);
    expect_out({8'h00, 6'h00});
    edge_sel_wdata = 1'b1;
    pulse(edge_sel_wr);
    expect_out({8'h00, 6'h04});
    edge_sel_wdata = 1'b0;
    pulse(edge_sel_wr);
    expect_out({8'h00, 6'h04});
    pulse(ext_req);
    expect_out({8'h00, 6'h1C});
    pulse(irq_ack);
    expect_out({8'h00, 6'h04});
    replacement_req = 1'b1;
    expect_out({8'h00, 6'h1C});
    pulse(irq_ack);
    pulse(ext_req);
    expect_out({8'h00, 6'h04});
    replacement_req = 1'b0;
    // A second reset clears the select; a write after the window must then be refused.
    arst_n = 1'b0;
    step(2);
    arst_n = 1'b1;
    expect_out({8'h00, 6'h00});
    repeat (PROT_WINDOW_ECLK) begin
      @(posedge clk_sys);
      while (!e_tick) @(posedge clk_sys);
    end
    step(1);
    edge_sel_wdata = 1'b1;
    pulse(edge_sel_wr);
    expect_out({8'h00, 6'h00});
    final_report;
  end
  initial begin
    step(5000);
    n_fail++;
    final_report;
  end
endmodule // maskable_irq_request_logic_tb_top
